// *** design/prog_port_pkg.sv ***
package prog_port_pkg;
  // ****************************************************************
  // Array geometry
  // ****************************************************************
  localparam int ROWS           = 44;
  localparam int ROW_BITS       = 132;
  localparam int ADDR_BITS      = 6;
  localparam int DATA_REG_BITS  = ROW_BITS + ADDR_BITS;
  localparam int SIG_BITS       = 64;
  localparam int SIG_FIELD_LO   = DATA_REG_BITS - ADDR_BITS - SIG_BITS;
  localparam int CFG_BITS       = 20;
  localparam int MACROCELLS     = CFG_BITS / 2;
  localparam int ID_BITS        = 8;
  localparam int INSTR_BITS     = 5;
  localparam int SYNC_STAGES    = 2;
  localparam logic [ADDR_BITS-1:0] SIG_ROW_ADDR = 6'h2c;

  // ****************************************************************
  // Instruction encodings
  // ****************************************************************
  localparam logic [INSTR_BITS-1:0] INSTR_NOP       = 5'h00;
  localparam logic [INSTR_BITS-1:0] INSTR_ROW_LOAD  = 5'h02;
  localparam logic [INSTR_BITS-1:0] INSTR_BULK_ERA  = 5'h03;
  localparam logic [INSTR_BITS-1:0] INSTR_ERA_ARRAY = 5'h05;
  localparam logic [INSTR_BITS-1:0] INSTR_ERA_CFG   = 5'h06;
  localparam logic [INSTR_BITS-1:0] INSTR_PROGRAM   = 5'h07;
  localparam logic [INSTR_BITS-1:0] INSTR_VERIFY    = 5'h0a;
  localparam logic [INSTR_BITS-1:0] INSTR_PRELOAD   = 5'h0d;
  localparam logic [INSTR_BITS-1:0] INSTR_BYPASS    = 5'h0e;
  localparam logic [INSTR_BITS-1:0] INSTR_CFG_LOAD  = 5'h14;

  // ****************************************************************
  // Types
  // ****************************************************************
  typedef enum logic [1:0] {
    ST_IDLE    = 2'h0,
    ST_SHIFT   = 2'h1,
    ST_EXECUTE = 2'h3
  } prog_state_e;

  typedef struct packed {
    logic shift_clk;
    logic mode;
    logic serial_in;
  } link_pins_s;

  typedef struct packed {
    logic rise;
    logic mode;
    logic serial_in;
  } link_event_s;
endpackage

// *** design/link_sampler.sv ***
`timescale 1ns/1ns
module link_sampler
  import prog_port_pkg::*;
(
  input  wire logic        core_clk,
  input  wire logic        rst_b,
  input  wire link_pins_s  pins,
  output link_event_s      evt
);
  // ****************************************************************
  // Synchronisers
  // ****************************************************************
  logic [2:0] meta_ff;
  logic [2:0] sync_ff;
  logic       clk_dly_ff;

  genvar g;
  generate
    for (g = 0; g < 3; g++) begin : g_sync
      always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
          meta_ff[g] <= 1'b0;
          sync_ff[g] <= 1'b0;
        end else begin
          meta_ff[g] <= pins[g];
          sync_ff[g] <= meta_ff[g];
        end
      end
    end
  endgenerate

  // Mode and serial input share the clock's latency, so they are sampled
  // at the shift clock edge they were set up for.
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      clk_dly_ff <= 1'b0;
    end else begin
      clk_dly_ff <= sync_ff[2];
    end
  end

  assign evt.rise      = sync_ff[2] & ~clk_dly_ff;
  assign evt.mode      = sync_ff[1];
  assign evt.serial_in = sync_ff[0];
endmodule // link_sampler

// *** design/serial_program_port.sv ***
`timescale 1ns/1ns
// Operation
// - 44 rows, signature row, configuration row
// - Row load register: 6 address, 132 data
// - Program writes loaded data to addressed row
// - Signature uses 64 data plus 6 address
// - Configuration shift: 20 bits, low bit first
// - Preload length equals registered output count
// - Command shift state tristates user I/Os
// - Instruction register is five bits
// - Three states steered by mode, serial input
// - Mode high, input low loads identifier
// - Mode low shifts identifier toward output
// - Lockstep states, individual instruction per device
// - Bypass passes serial input to output
// - Mode and input high enter shift state
// - Registers take least significant bit first
// - Instruction encodings as listed
// - Execute state: mode, input low runs
module serial_program_port
  import prog_port_pkg::*;
#(
  parameter logic [ID_BITS-1:0] DEVICE_ID = 8'h5a // Arbitrary value.
)(
  input  wire logic                core_clk,
  input  wire logic                rst_b,
  input  wire logic                shift_clk,
  input  wire logic                mode,
  input  wire logic                serial_in,
  output logic                     serial_out,
  output logic                     user_io_hiz,
  output logic [CFG_BITS-1:0]      config_bits,
  output logic [MACROCELLS-1:0]    preload_value,
  input  wire logic [ADDR_BITS-1:0] rd_row,
  output logic [ROW_BITS-1:0]      rd_data,
  output logic [SIG_BITS-1:0]      user_signature_row
);
  // ****************************************************************
  // Link sampling
  // ****************************************************************
  link_pins_s  pins;
  link_event_s evt;

  assign pins.shift_clk = shift_clk;
  assign pins.mode      = mode;
  assign pins.serial_in = serial_in;

  link_sampler u_sampler (
    .core_clk (core_clk),
    .rst_b    (rst_b),
    .pins     (pins),
    .evt      (evt)
  );

  // ****************************************************************
  // State machine
  // ****************************************************************
  prog_state_e                state_ff;
  prog_state_e                nxt_state;
  logic [ID_BITS-1:0]         id_ff;
  logic [INSTR_BITS-1:0]      instr_ff;
  logic [DATA_REG_BITS-1:0]   data_ff;
  logic [CFG_BITS-1:0]        cfg_ff;
  logic [MACROCELLS-1:0]      preload_ff;
  logic [MACROCELLS-1:0]      nxt_preload;
  logic                       preload_tail;
  logic [ROW_BITS-1:0]        array_ff [ROWS];
  logic [SIG_BITS-1:0]        sig_ff;
  logic                       serial_out_ff;
  logic                       hiz_ff;
  logic                       run_cmd;
  logic                       shift_data;
  logic                       shifting_instr;
  logic [ADDR_BITS-1:0]       row_addr;

  // Shifting instructions use mode low as a data clock; the rest use it as
  // the run strobe, so a shifting instruction never runs by accident.
  assign shifting_instr = (instr_ff == INSTR_ROW_LOAD) || (instr_ff == INSTR_CFG_LOAD) ||
                          (instr_ff == INSTR_PRELOAD) || (instr_ff == INSTR_BYPASS);
  assign shift_data = evt.rise && !evt.mode && (state_ff == ST_EXECUTE);
  assign run_cmd    = shift_data && !evt.serial_in && !shifting_instr;
  assign row_addr   = data_ff[DATA_REG_BITS-1 -: ADDR_BITS];

  always_comb begin
    nxt_state = state_ff;
    if (evt.rise && evt.mode) begin
      if (!evt.serial_in) begin
        nxt_state = ST_IDLE;
      end else begin
        case (state_ff)
          ST_IDLE:    nxt_state = ST_SHIFT;
          ST_SHIFT:   nxt_state = ST_EXECUTE;
          ST_EXECUTE: nxt_state = ST_SHIFT;
          default:    nxt_state = ST_IDLE;
        endcase
      end
    end
  end

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      state_ff <= ST_IDLE;
    end else begin
      state_ff <= nxt_state;
    end
  end

  // ****************************************************************
  // User I/O release
  // ****************************************************************
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      hiz_ff <= 1'b0;
    end else begin
      hiz_ff <= (nxt_state != ST_IDLE);
    end
  end

  // ****************************************************************
  // Identifier and instruction registers
  // ****************************************************************
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      id_ff <= '0;
    end else if (evt.rise && state_ff == ST_IDLE) begin
      if (evt.mode && !evt.serial_in) begin
        id_ff <= DEVICE_ID;
      end else if (!evt.mode) begin
        id_ff <= {evt.serial_in, id_ff[ID_BITS-1:1]};
      end
    end
  end

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      instr_ff <= INSTR_NOP;
    end else if (evt.rise && !evt.mode && state_ff == ST_SHIFT) begin
      instr_ff <= {evt.serial_in, instr_ff[INSTR_BITS-1:1]};
    end
  end

  // ****************************************************************
  // Row load register and array
  // ****************************************************************
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      data_ff <= '0;
    end else if (shift_data && instr_ff == INSTR_ROW_LOAD) begin
      data_ff <= {evt.serial_in, data_ff[DATA_REG_BITS-1:1]};
    end else if (run_cmd && instr_ff == INSTR_VERIFY) begin
      if (row_addr == SIG_ROW_ADDR) begin
        data_ff[ROW_BITS-1 -: SIG_BITS] <= sig_ff;
      end else if (row_addr < ADDR_BITS'(ROWS)) begin
        data_ff[ROW_BITS-1:0] <= array_ff[row_addr];
      end
    end
  end

  // Erased cells read as zero; a row changes only on reset, an erase or a program of its address.
  genvar r;
  generate
    for (r = 0; r < ROWS; r++) begin : g_row
      always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
          array_ff[r] <= '0;
        end else if (run_cmd && (instr_ff == INSTR_BULK_ERA || instr_ff == INSTR_ERA_ARRAY)) begin
          array_ff[r] <= '0;
        end else if (run_cmd && instr_ff == INSTR_PROGRAM && row_addr == ADDR_BITS'(r)) begin
          array_ff[r] <= data_ff[ROW_BITS-1:0];
        end
      end
    end
  endgenerate

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      sig_ff <= '0;
    end else if (run_cmd && (instr_ff == INSTR_BULK_ERA || instr_ff == INSTR_ERA_ARRAY)) begin
      sig_ff <= '0;
    end else if (run_cmd && instr_ff == INSTR_PROGRAM && row_addr == SIG_ROW_ADDR) begin
      sig_ff <= data_ff[ROW_BITS-1 -: SIG_BITS];
    end
  end

  // ****************************************************************
  // Configuration row
  // ****************************************************************
  // Bit 2i holds macrocell i high select bit, bit 2i+1 its low select bit.
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      cfg_ff <= '0;
    end else if (run_cmd && (instr_ff == INSTR_BULK_ERA || instr_ff == INSTR_ERA_CFG)) begin
      cfg_ff <= '0;
    end else if (shift_data && instr_ff == INSTR_CFG_LOAD) begin
      cfg_ff <= {evt.serial_in, cfg_ff[CFG_BITS-1:1]};
    end
  end

  // ****************************************************************
  // Output preload
  // ****************************************************************
  // A macrocell whose low select bit is set is a registered output and joins
  // the chain; the others are skipped, so the chain length follows the
  // configuration without a separate length register. Bits enter at the top
  // so that the first bit shifted in ends in the lowest registered macrocell.
  always_comb begin
    logic carry;
    carry        = evt.serial_in;
    nxt_preload  = preload_ff;
    for (int i = MACROCELLS - 1; i >= 0; i--) begin
      if (cfg_ff[2*i+1]) begin
        nxt_preload[i] = carry;
        carry          = preload_ff[i];
      end
    end
    preload_tail = carry;
  end

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      preload_ff <= '0;
    end else if (shift_data && instr_ff == INSTR_PRELOAD) begin
      preload_ff <= nxt_preload;
    end
  end

  // ****************************************************************
  // Serial output
  // ****************************************************************
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      serial_out_ff <= 1'b0;
    end else begin
      case (state_ff)
        ST_IDLE:    serial_out_ff <= id_ff[0];
        ST_SHIFT:   serial_out_ff <= instr_ff[0];
        ST_EXECUTE: begin
          case (instr_ff)
            INSTR_ROW_LOAD: serial_out_ff <= data_ff[0];
            INSTR_CFG_LOAD: serial_out_ff <= cfg_ff[0];
            INSTR_PRELOAD:  serial_out_ff <= preload_tail;
            INSTR_BYPASS:   serial_out_ff <= evt.serial_in;
            default:        serial_out_ff <= 1'b0;
          endcase
        end
        default:    serial_out_ff <= 1'b0;
      endcase
    end
  end

  assign serial_out         = serial_out_ff;
  assign user_io_hiz        = hiz_ff;
  assign config_bits        = cfg_ff;
  assign preload_value      = preload_ff;
  assign user_signature_row = sig_ff;
  assign rd_data            = (rd_row < ADDR_BITS'(ROWS)) ? array_ff[rd_row] : '0;
endmodule // serial_program_port

// *** tb/prog_ctrl_model.sv ***
`timescale 1ns/1ns
module prog_ctrl_model (
  output logic      shift_clk,
  output logic      mode,
  output logic      serial_in,
  input  wire logic serial_out
);
  // ****
  // Controller side of the link
  // ****
  logic so;

  initial begin
    shift_clk = 1'b0;
    mode = 1'b1;
    serial_in = 1'b0;
  end

  // The data line is turned round after its hold time, so a stale level never looks valid.
  task automatic pulse(input logic m, input logic d);
    mode = m;
    serial_in = d;
    #40 shift_clk = 1'b1;
    #36 so = serial_out;
    #4 serial_in = ~d;
    #40 shift_clk = 1'b0;
    #40;
  endtask

  task automatic read_ids(output logic [63:0] ids, output int n);
    logic [7:0] last;
    ids = '0;
    pulse(1'b1, 1'b0);
    ids[0] = so;
    last = {7'h00, so};
    for (n = 1; n < 64 && last != 8'hff; n++) begin
      pulse(1'b0, 1'b1);
      ids[n] = so;
      last = {last[6:0], so};
    end
  endtask

  task automatic to_state();
    pulse(1'b1, 1'b1);
  endtask

  task automatic send(input logic [137:0] v, input int len);
    for (int i = 0; i < len; i++) pulse(1'b0, v[i]);
  endtask

  task automatic instr(input logic [4:0] c);
    to_state();
    send(138'(c), 5);
    to_state();
  endtask

  task automatic run();
    pulse(1'b0, 1'b0);
  endtask
endmodule // prog_ctrl_model

// *** tb/serial_program_port_assertions.sv ***
`timescale 1ns/1ns
module serial_program_port_assertions
  import prog_port_pkg::*;
(
  input wire logic                  core_clk,
  input wire logic                  rst_b,
  input wire logic                  shift_clk,
  input wire logic                  mode,
  input wire logic                  serial_in,
  input wire logic                  serial_out,
  input wire logic                  user_io_hiz,
  input wire logic [CFG_BITS-1:0]   config_bits,
  input wire logic [MACROCELLS-1:0] preload_value,
  input wire logic [ADDR_BITS-1:0]  rd_row,
  input wire logic [ROW_BITS-1:0]   rd_data,
  input wire logic [SIG_BITS-1:0]   user_signature_row
);
  // ****
  // Link edge tracking
  // ****
  logic       sclk_ff, m_ff, d_ff, din_ff;
  logic [3:0] age_ff, din_age_ff;
  wire        rise = shift_clk && !sclk_ff;

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) sclk_ff <= 1'b0;
    else sclk_ff <= shift_clk;
  end

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      m_ff <= 1'b0;
      d_ff <= 1'b0;
      age_ff <= 4'hf;
    end else if (rise) begin
      m_ff <= mode;
      d_ff <= serial_in;
      age_ff <= 4'h0;
    end else if (age_ff != 4'hf) begin
      age_ff <= age_ff + 4'h1;
    end
  end

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      din_ff <= 1'b0;
      din_age_ff <= 4'hf;
    end else begin
      din_ff <= serial_in;
      din_age_ff <= (serial_in != din_ff) ? 4'h0 : ((din_age_ff == 4'hf) ? 4'hf : din_age_ff + 4'h1);
    end
  end

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_b);

  idle_hiz_a: assert property (rise && mode && !serial_in |-> ##[1:8] !user_io_hiz)
    else $error("user pins not released after a return to idle");
  shift_hiz_a: assert property (rise && mode && serial_in |-> ##[1:8] user_io_hiz)
    else $error("user pins not tristated on a state step");
  hiz_cause_a: assert property ($rose(user_io_hiz) |-> m_ff && d_ff && age_ff <= 4'h8)
    else $error("user pins tristated without a state step");
  out_cause_a: assert property ($changed(serial_out) |-> age_ff <= 4'h8 || din_age_ff <= 4'h6)
    else $error("serial output moved with no link edge");
  cfg_cause_a: assert property ($changed(config_bits) |-> !m_ff && age_ff <= 4'h8)
    else $error("configuration row moved with no shift edge");
  pre_cause_a: assert property ($changed(preload_value) |-> !m_ff && age_ff <= 4'h8)
    else $error("preload register moved with no shift edge");
  sig_cause_a: assert property ($changed(user_signature_row) |-> !m_ff && !d_ff && age_ff <= 4'h8)
    else $error("signature row moved without a run edge");
  row_cause_a: assert property ($changed(rd_data) && $stable(rd_row) |-> !m_ff && !d_ff && age_ff <= 4'h8)
    else $error("array row moved without a run edge");
  row_range_a: assert property (rd_row >= 6'h2c |-> rd_data == '0)
    else $error("read beyond the array rows is not zero");
endmodule // serial_program_port_assertions

bind serial_program_port serial_program_port_assertions i_serial_program_port_assertions (
  .core_clk(core_clk), .rst_b(rst_b), .shift_clk(shift_clk), .mode(mode), .serial_in(serial_in),
  .serial_out(serial_out), .user_io_hiz(user_io_hiz), .config_bits(config_bits),
  .preload_value(preload_value), .rd_row(rd_row), .rd_data(rd_data), .user_signature_row(user_signature_row));

// *** tb/serial_program_port_tb_top.sv ***
`timescale 1ns/1ns
module serial_program_port_tb_top;
  import prog_port_pkg::*;
  // ****
  // Bench and checks
  // ****
  localparam logic [ID_BITS-1:0] DEV_ID = 8'h3c; // Arbitrary value.
  logic                  core_clk, rst_b, shift_clk, mode, serial_in, serial_out, user_io_hiz;
  logic [CFG_BITS-1:0]   config_bits;
  logic [MACROCELLS-1:0] preload_value, pmask, pexp;
  logic [ADDR_BITS-1:0]  rd_row;
  logic [ROW_BITS-1:0]   rd_data;
  logic [SIG_BITS-1:0]   user_signature_row;
  logic [15:0]           rnd = 16'hc2fa;
  int                    mismatches = 0;
  int                    n_checks = 0;

  serial_program_port #(.DEVICE_ID(DEV_ID)) i_serial_program_port (
    .core_clk(core_clk), .rst_b(rst_b), .shift_clk(shift_clk), .mode(mode), .serial_in(serial_in),
    .serial_out(serial_out), .user_io_hiz(user_io_hiz), .config_bits(config_bits),
    .preload_value(preload_value), .rd_row(rd_row), .rd_data(rd_data), .user_signature_row(user_signature_row));
  prog_ctrl_model i_prog_ctrl_model (
    .shift_clk(shift_clk), .mode(mode), .serial_in(serial_in), .serial_out(serial_out));

  initial begin
    core_clk = 1'b0;
    forever #2 core_clk = ~core_clk;
  end

  task automatic check(input logic [255:0] seen, input logic [255:0] exp);
    n_checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("FAIL %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic rand_vec(output logic [137:0] v);
    for (int i = 0; i < 138; i++) begin
      rnd = {rnd[14:0], rnd[15] ^ rnd[13] ^ rnd[12] ^ rnd[10]};
      v[i] = rnd[0];
    end
  endtask

  task automatic end_of_test();
    if (mismatches == 0 && n_checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask

  initial begin
    logic [137:0] row, w, cfg;
    logic [63:0]  ids;
    int           n, k;
    rd_row = 6'h3f;
    rst_b = 1'b0;
    repeat (5) @(posedge core_clk);
    #1 rst_b = 1'b1;
    repeat (4) @(posedge core_clk);
    #1;
    check(user_io_hiz, 1'b0);
    check({config_bits, user_signature_row}, '0);
    check(rd_data, '0);
    i_prog_ctrl_model.read_ids(ids, n);
    w = '1;
    w[7:0] = DEV_ID;
    for (k = 7; w[k-7 +: 8] !== 8'hff; k++);
    check(ids[7:0], DEV_ID);
    check(138'(n), 138'(k + 1));
    rand_vec(row);
    row[137:132] = 6'(rnd % 16'd44);
    i_prog_ctrl_model.instr(INSTR_ROW_LOAD);
    check(user_io_hiz, 1'b1);
    i_prog_ctrl_model.send(row, 138);
    i_prog_ctrl_model.instr(INSTR_PROGRAM);
    i_prog_ctrl_model.run();
    rd_row = row[137:132];
    #1 check(rd_data, row[131:0]);
    rand_vec(w);
    w[69:64] = SIG_ROW_ADDR;
    i_prog_ctrl_model.instr(INSTR_ROW_LOAD);
    i_prog_ctrl_model.send(w, 70);
    i_prog_ctrl_model.instr(INSTR_PROGRAM);
    i_prog_ctrl_model.run();
    check(user_signature_row, w[63:0]);
    i_prog_ctrl_model.instr(INSTR_ROW_LOAD);
    i_prog_ctrl_model.send(138'(row[137:132]), 6);
    i_prog_ctrl_model.instr(INSTR_VERIFY);
    i_prog_ctrl_model.run();
    i_prog_ctrl_model.instr(INSTR_ROW_LOAD);
    w[0] = serial_out;
    for (k = 1; k < 132; k++) begin
      i_prog_ctrl_model.pulse(1'b0, 1'b0);
      w[k] = i_prog_ctrl_model.so;
    end
    check(w[131:0], row[131:0]);
    rand_vec(cfg);
    i_prog_ctrl_model.instr(INSTR_CFG_LOAD);
    i_prog_ctrl_model.send(cfg, 20);
    check(config_bits, cfg[19:0]);
    rand_vec(w);
    pmask = '0;
    pexp = '0;
    n = 0;
    for (k = 0; k < MACROCELLS; k++) begin
      if (cfg[2*k+1]) begin
        pmask[k] = 1'b1;
        pexp[k] = w[n];
        n++;
      end
    end
    i_prog_ctrl_model.instr(INSTR_PRELOAD);
    i_prog_ctrl_model.send(w, n);
    check(preload_value & pmask, pexp);
    i_prog_ctrl_model.instr(INSTR_BYPASS);
    for (k = 0; k < 8; k++) begin
      i_prog_ctrl_model.pulse(1'b0, w[k]);
      check(i_prog_ctrl_model.so, w[k]);
    end
    i_prog_ctrl_model.instr(INSTR_NOP);
    i_prog_ctrl_model.run();
    check({config_bits, rd_data}, {cfg[19:0], row[131:0]});
    i_prog_ctrl_model.instr(INSTR_ERA_ARRAY);
    i_prog_ctrl_model.run();
    check({config_bits, rd_data, user_signature_row}, {cfg[19:0], 196'h0});
    i_prog_ctrl_model.instr(INSTR_ERA_CFG);
    i_prog_ctrl_model.run();
    check(config_bits, '0);
    i_prog_ctrl_model.instr(INSTR_BULK_ERA);
    i_prog_ctrl_model.run();
    check(rd_data, '0);
    i_prog_ctrl_model.pulse(1'b1, 1'b0);
    check(user_io_hiz, 1'b0);
    end_of_test();
  end
endmodule // serial_program_port_tb_top
